// ### common/fsr_pkg.sv
// shared constants and types of the flash status register block
package fsr_pkg;

   // -----------------------------------------------------------------
   // command opcodes seen on the serial link
   // -----------------------------------------------------------------
   localparam logic [7:0] OP_WRITE_STATUS_ONE = 8'h01;
   localparam logic [7:0] OP_WRITE_STATUS_TWO = 8'h31;
   localparam logic [7:0] OP_WRITE_ENABLE     = 8'h06;
   localparam logic [7:0] OP_WRITE_DISABLE    = 8'h04;
   localparam logic [7:0] OP_READ_STATUS      = 8'h05;

   // -----------------------------------------------------------------
   // status byte one fields
   // -----------------------------------------------------------------
   localparam int S1_LOCK   = 7;
   localparam int S1_FAIL   = 5;
   localparam int S1_WPP    = 4;
   localparam int S1_SWP_HI = 3;
   localparam int S1_SWP_LO = 2;
   localparam int S1_WEL    = 1;
   localparam int S1_BUSY   = 0;

   // -----------------------------------------------------------------
   // status byte two fields
   // -----------------------------------------------------------------
   localparam int S2_RST_PERMIT  = 4;
   localparam int S2_LOCK_PERMIT = 3;
   localparam int S2_PROG_SUSP   = 2;
   localparam int S2_ERASE_SUSP  = 1;
   localparam int S2_BUSY        = 0;

   // -----------------------------------------------------------------
   // write data fields and codes
   // -----------------------------------------------------------------
   localparam int WD1_LOCK   = 7;
   localparam int WD1_GLB_HI = 5;
   localparam int WD1_GLB_LO = 2;
   localparam int WD2_RST    = 4;
   localparam int WD2_LOCK   = 3;
   localparam logic [3:0] GLB_PROTECT   = 4'hF;
   localparam logic [3:0] GLB_UNPROTECT = 4'h0;
   localparam logic [1:0] SWP_NONE = 2'h0;
   localparam logic [1:0] SWP_SOME = 2'h1;
   localparam logic [1:0] SWP_ALL  = 2'h3;

   // reset values of the stored bits
   localparam logic LOCK_RESET   = 1'b0;
   localparam logic WEL_RESET    = 1'b0;
   localparam logic PERMIT_RESET = 1'b0;
   localparam logic FAIL_RESET   = 1'b0;

   // link counters
   localparam logic [2:0] LAST_BIT  = 3'h7;
   localparam logic [1:0] BYTES_MAX = 2'h3;
   localparam logic [1:0] BYTES_CMD = 2'h1;
   localparam logic [1:0] BYTES_DAT = 2'h2;

   // command classes handed in by the device's main decoder
   typedef enum logic [2:0] {
      FSR_CMD_PROG_ERASE,
      FSR_CMD_PROTECT,
      FSR_CMD_UNPROTECT,
      FSR_CMD_LOCKDOWN,
      FSR_CMD_FREEZE,
      FSR_CMD_OTP,
      FSR_CMD_CONFIG
   } fsr_cmd_type;

   // summary of one finished frame on the link
   typedef struct packed {
      logic [7:0] opcode;
      logic [7:0] data;
      logic [1:0] nbytes;
      logic       aligned;
   } fsr_frame_type;

endpackage

// ### hdl/fsr_status_ctrl.sv
// status register bank of a serial flash with its write-status commands
//
// What this block does
// [RULE1] protection lock set: sector protect, unprotect and global operations are refused.
// [RULE2] protection lock powers up 0, soft reset leaves it; 0 allows changes.
// [RULE3] with write-protect pin asserted, lock only rises; clear attempt ignored, latch cleared.
// [RULE4] every program or erase end updates the fail flag from its result.
// [RULE5] aborted program or erase never sets the fail flag.
// [RULE6] pin state bit mirrors the write-protect pin, read only.
// [RULE7] protect summary reports none, some or all sectors protected.
// [RULE8] write enable latch low: all write-protected commands refused.
// [RULE9] write enable latch is 0 after power-up and any reset.
// [RULE10] latch clears on hold abort, write disable, and any protected command end.
// [RULE11] incomplete or unknown opcode leaves the latch unchanged.
// [RULE12] soft reset permit powers up 0; soft reset accepted only when 1.
// [RULE13] soft reset permit changes only by status write two or power.
// [RULE14] lockdown permit powers up 0; lockdown and freeze accepted only when 1.
// [RULE15] lockdown permit never clears by itself or by soft reset.
// [RULE16] after freeze, lockdown permit stays 0; later writes update only reset permit.
// [RULE17] suspend flags show program-suspend and erase-suspend states.
// [RULE18] busy flag reads 1 during program or erase; host polls status.
// [RULE19] opcode 01h plus byte updates lock at frame end and clears latch.
// [RULE20] data bit 7 is the lock, bits 5:2 request global operations.
// [RULE21] frame not ending on a byte boundary aborts, clears latch only.
// [RULE22] opcode 31h plus byte: bit 4 reset permit, bit 3 lockdown permit.
// [RULE23] summary codes: 00 none, 01 some, 11 all protected.
// [RULE24] byte one: lock, zero, fail, pin, summary, latch, busy.
// [RULE25] byte two: zeros, reset permit, lockdown permit, suspends, busy.
// [RULE26] a complete byte-aligned write enable sets the latch.
`timescale 1ns/100ps

module fsr_status_ctrl (
   // system clock and reset
   input  wire logic                 clk_sys,
   input  wire logic                 reset,
   // serial link
   input  wire logic                 spi_sclk,
   input  wire logic                 spi_cs_n,
   input  wire logic                 spi_mosi,
   output logic                      spi_miso,
   // write-protect pin, low when asserted
   input  wire logic                 wp_pin_n,
   // state of the array engine
   input  wire logic                 core_busy,
   input  wire logic                 core_prog_susp,
   input  wire logic                 core_erase_susp,
   input  wire logic                 core_any_prot,
   input  wire logic                 core_all_prot,
   // command requests from the main decoder
   input  wire logic                 cmd_valid,
   input  fsr_pkg::fsr_cmd_type      cmd_kind,
   input  wire logic                 cmd_end,
   input  wire logic                 hold_abort,
   input  wire logic                 soft_reset_req,
   // program or erase result
   input  wire logic                 op_done,
   input  wire logic                 op_fail,
   input  wire logic                 op_aborted,
   // grants and requests to the array engine
   output logic                      cmd_grant,
   output logic                      cmd_refuse,
   output logic                      soft_reset_go,
   output logic                      global_protect_go,
   output logic                      global_unprotect_go,
   output logic                      protection_lock_bit,
   output logic                      soft_reset_permit,
   output logic                      lockdown_permit
);
   import fsr_pkg::*;

   // -----------------------------------------------------------------
   // link side, on the serial clock
   // -----------------------------------------------------------------
   logic          armed_q;
   logic [2:0]    bit_cnt_q;
   logic [1:0]    nbytes_q;
   logic [7:0]    shift_q;
   logic [7:0]    opcode_q;
   logic [7:0]    data_q;
   logic          reading_q;
   logic          sel_q;
   logic          miso_q;
   logic [15:0]   stat_meta_q;
   logic [15:0]   stat_link_q;
   wire           frame_idle;
   wire  [2:0]    cur_bit;
   wire  [1:0]    cur_bytes;
   wire  [7:0]    shift_d;
   wire           byte_done;
   wire  [3:0]    out_index;
   logic [15:0]   status_word;

   // the link clock stands still between frames, so chip select itself re-arms
   assign frame_idle = spi_cs_n | reset;
   assign cur_bit    = armed_q ? 3'h0 : bit_cnt_q;
   assign cur_bytes  = armed_q ? 2'h0 : nbytes_q;
   assign shift_d    = {shift_q[6:0], spi_mosi};
   assign byte_done  = (cur_bit == LAST_BIT);
   assign out_index  = {sel_q, ~bit_cnt_q};

   // first edge of a frame marker
   always_ff @(posedge spi_sclk or posedge frame_idle) begin
      if (frame_idle) begin
         armed_q <= 1'b1;
      end else begin
         armed_q <= 1'b0;
      end
   end

   // bit and byte counting; values survive chip select rise for the system side
   always_ff @(posedge spi_sclk or posedge reset) begin
      if (reset) begin
         bit_cnt_q <= 3'h0;
         nbytes_q  <= 2'h0;
         shift_q   <= 8'h00;
         opcode_q  <= 8'h00;
         data_q    <= 8'h00;
      end else begin
         bit_cnt_q <= cur_bit + 3'h1;
         shift_q   <= shift_d;
         nbytes_q  <= cur_bytes;
         if (byte_done) begin
            nbytes_q <= (cur_bytes == BYTES_MAX) ? BYTES_MAX : cur_bytes + 2'h1;
            if (cur_bytes == 2'h0) begin
               opcode_q <= shift_d;
            end
            // extra bytes after the data byte are dropped
            if (cur_bytes == BYTES_CMD) begin
               data_q <= shift_d;
            end
         end
      end
   end

   // status read: bytes one and two alternate for as long as the host clocks
   always_ff @(posedge spi_sclk or posedge reset) begin
      if (reset) begin
         reading_q <= 1'b0;
         sel_q     <= 1'b0;
      end else if (armed_q) begin
         reading_q <= 1'b0;
         sel_q     <= 1'b0;
      end else if (byte_done) begin
         if (cur_bytes == 2'h0) begin
            reading_q <= (shift_d == OP_READ_STATUS);
         end else begin
            sel_q <= ~sel_q;
         end
      end
   end

   // status word crosses as a slow level; one byte may show a mid-update mix, the next poll is fresh
   always_ff @(posedge spi_sclk or posedge reset) begin
      if (reset) begin
         stat_meta_q <= 16'h0000;
         stat_link_q <= 16'h0000;
      end else begin
         stat_meta_q <= status_word;
         stat_link_q <= stat_meta_q;
      end
   end

   // serial output launched on the falling edge, most significant bit first
   always_ff @(negedge spi_sclk or posedge reset) begin
      if (reset) begin
         miso_q <= 1'b0;
      end else begin
         miso_q <= reading_q & stat_link_q[out_index];
      end
   end

   assign spi_miso = miso_q;

   // -----------------------------------------------------------------
   // pin synchronisers on the system clock
   // -----------------------------------------------------------------
   logic [2:0]    cs_sync_q;
   logic [2:0]    wp_sync_q;
   logic          cs_filt_q;
   logic          wp_filt_q;
   wire           cs_agree;
   wire           frame_end;

   assign cs_agree  = (cs_sync_q[1] == cs_sync_q[2]);
   // frame end: filtered chip select goes high
   assign frame_end = cs_agree & cs_sync_q[2] & ~cs_filt_q;

   // three stages; a change counts once stages two and three agree
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         cs_sync_q <= 3'h7;
         wp_sync_q <= 3'h7;
         cs_filt_q <= 1'b1;
         wp_filt_q <= 1'b1;
      end else begin
         cs_sync_q <= {cs_sync_q[1:0], spi_cs_n};
         wp_sync_q <= {wp_sync_q[1:0], wp_pin_n};
         if (cs_agree) begin
            cs_filt_q <= cs_sync_q[2];
         end
         if (wp_sync_q[1] == wp_sync_q[2]) begin
            wp_filt_q <= wp_sync_q[2];
         end
      end
   end

   // -----------------------------------------------------------------
   // frame decode on the system clock
   // -----------------------------------------------------------------
   fsr_frame_type frame;
   logic          lock_q;
   logic          wel_q;
   wire           wp_asserted;
   wire           op_whole;
   wire           frame_ok;
   wire           is_ws1;
   wire           is_ws2;
   wire           is_wren;
   wire           is_wrdi;
   wire           ws1_apply;
   wire           ws2_apply;
   wire           ws1_blocked;
   wire  [3:0]    glb_code;

   // link counters are quiet once chip select is high, so the snapshot is stable
   assign frame.opcode  = opcode_q;
   assign frame.data    = data_q;
   assign frame.nbytes  = nbytes_q;
   assign frame.aligned = (bit_cnt_q == 3'h0);

   assign wp_asserted = ~wp_filt_q;
   // [RULE11] whole opcode needed
   assign op_whole    = frame_end & (frame.nbytes != 2'h0);
   // [RULE21] byte boundary check
   assign frame_ok    = frame.aligned & (frame.nbytes >= BYTES_DAT);
   assign is_ws1      = op_whole & (frame.opcode == OP_WRITE_STATUS_ONE);
   assign is_ws2      = op_whole & (frame.opcode == OP_WRITE_STATUS_TWO);
   assign is_wren     = op_whole & frame.aligned & (frame.opcode == OP_WRITE_ENABLE);
   assign is_wrdi     = op_whole & (frame.opcode == OP_WRITE_DISABLE);
   // [RULE3] clear under pin ignored
   assign ws1_blocked = wp_asserted & lock_q & ~frame.data[WD1_LOCK];
   // [RULE19] write one needs latch
   assign ws1_apply   = is_ws1 & wel_q & frame_ok & ~ws1_blocked;
   // [RULE22] write two needs latch
   assign ws2_apply   = is_ws2 & wel_q & frame_ok;
   assign glb_code    = frame.data[WD1_GLB_HI:WD1_GLB_LO];

   // -----------------------------------------------------------------
   // stored status bits
   // -----------------------------------------------------------------
   logic          lock_d;
   logic          wel_d;
   logic          rst_permit_q;
   logic          rst_permit_d;
   logic          ld_permit_q;
   logic          ld_permit_d;
   logic          frozen_q;
   logic          frozen_d;
   logic          fail_q;
   logic          fail_d;
   wire           cmd_ok;
   wire           wel_clear;

   // [RULE8] latch gates every protected command
   // [RULE1] lock refuses sector protection changes
   // [RULE14] lockdown and freeze need the permit
   assign cmd_ok = cmd_valid & wel_q
                 & ~(lock_q & (cmd_kind == FSR_CMD_PROTECT || cmd_kind == FSR_CMD_UNPROTECT))
                 & ~(~ld_permit_q & (cmd_kind == FSR_CMD_LOCKDOWN || cmd_kind == FSR_CMD_FREEZE));

   // [RULE10] automatic latch clears
   assign wel_clear = hold_abort | is_wrdi | is_ws1 | is_ws2 | cmd_end
                    | (soft_reset_req & rst_permit_q);

   // next values of the stored bits
   always_comb begin
      lock_d       = lock_q;
      rst_permit_d = rst_permit_q;
      ld_permit_d  = ld_permit_q;
      frozen_d     = frozen_q | (cmd_ok & (cmd_kind == FSR_CMD_FREEZE));
      fail_d       = fail_q;
      wel_d        = wel_q;
      // [RULE20] bit seven carries the lock
      if (ws1_apply) begin
         lock_d = frame.data[WD1_LOCK];
      end
      // [RULE13] only write two moves the reset permit
      if (ws2_apply) begin
         rst_permit_d = frame.data[WD2_RST];
      end
      // [RULE16] frozen permit ignores writes
      if (ws2_apply & ~frozen_q) begin
         ld_permit_d = frame.data[WD2_LOCK];
      end
      if (frozen_d) begin
         ld_permit_d = 1'b0;
      end
      // [RULE4] result of each program or erase
      // [RULE5] aborts leave the flag alone
      if (op_done & ~op_aborted) begin
         fail_d = op_fail;
      end
      // [RULE26] write enable sets; set wins over a clear in the same cycle
      if (wel_clear) begin
         wel_d = 1'b0;
      end
      if (is_wren) begin
         wel_d = 1'b1;
      end
   end

   // [RULE2] [RULE9] [RULE12] [RULE15] power-up values; soft reset touches none but the latch
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         lock_q       <= LOCK_RESET;
         wel_q        <= WEL_RESET;
         rst_permit_q <= PERMIT_RESET;
         ld_permit_q  <= PERMIT_RESET;
         frozen_q     <= 1'b0;
         fail_q       <= FAIL_RESET;
      end else begin
         lock_q       <= lock_d;
         wel_q        <= wel_d;
         rst_permit_q <= rst_permit_d;
         ld_permit_q  <= ld_permit_d;
         frozen_q     <= frozen_d;
         fail_q       <= fail_d;
      end
   end

   // -----------------------------------------------------------------
   // status bytes
   // -----------------------------------------------------------------
   logic [1:0]    software_protect_summary;

   // [RULE7] [RULE23] protect summary from the sector registers
   always_comb begin
      if (core_all_prot) begin
         software_protect_summary = SWP_ALL;
      end else if (core_any_prot) begin
         software_protect_summary = SWP_SOME;
      end else begin
         software_protect_summary = SWP_NONE;
      end
   end

   // [RULE24] [RULE25] byte layouts; byte two sits high in the word
   // [RULE6] pin bit is 0 while the pin is asserted
   // [RULE17] [RULE18] suspend and busy straight from the engine
   always_comb begin
      status_word                         = 16'h0000;
      status_word[S1_LOCK]                = lock_q;
      status_word[S1_FAIL]                = fail_q;
      status_word[S1_WPP]                 = wp_filt_q;
      status_word[S1_SWP_HI:S1_SWP_LO]    = software_protect_summary;
      status_word[S1_WEL]                 = wel_q;
      status_word[S1_BUSY]                = core_busy;
      status_word[8 + S2_RST_PERMIT]      = rst_permit_q;
      status_word[8 + S2_LOCK_PERMIT]     = ld_permit_q;
      status_word[8 + S2_PROG_SUSP]       = core_prog_susp;
      status_word[8 + S2_ERASE_SUSP]      = core_erase_susp;
      status_word[8 + S2_BUSY]            = core_busy;
   end

   // -----------------------------------------------------------------
   // registered requests to the array engine
   // -----------------------------------------------------------------
   logic          grant_q;
   logic          refuse_q;
   logic          rst_go_q;
   logic          gprot_q;
   logic          gunprot_q;

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         grant_q   <= 1'b0;
         refuse_q  <= 1'b0;
         rst_go_q  <= 1'b0;
         gprot_q   <= 1'b0;
         gunprot_q <= 1'b0;
      end else begin
         grant_q   <= cmd_ok;
         refuse_q  <= cmd_valid & ~cmd_ok;
         // [RULE12] soft reset only with its permit
         rst_go_q  <= soft_reset_req & rst_permit_q;
         // [RULE1] global operations judged on the prior lock value
         gprot_q   <= ws1_apply & ~lock_q & (glb_code == GLB_PROTECT);
         gunprot_q <= ws1_apply & ~lock_q & (glb_code == GLB_UNPROTECT);
      end
   end

   assign cmd_grant           = grant_q;
   assign cmd_refuse          = refuse_q;
   assign soft_reset_go       = rst_go_q;
   assign global_protect_go   = gprot_q;
   assign global_unprotect_go = gunprot_q;
   assign protection_lock_bit = lock_q;
   assign soft_reset_permit   = rst_permit_q;
   assign lockdown_permit     = ld_permit_q;

endmodule

// ### test/fsr_status_ctrl_checker.sv
// concurrent checks on the ports of the flash status register block
`timescale 1ns/100ps

module fsr_status_ctrl_checker
   import fsr_pkg::*;
(
   // clocks, reset and pins
   input wire logic           clk_sys, reset, spi_sclk, spi_cs_n, spi_mosi, spi_miso, wp_pin_n,
   // engine state and requests
   input wire logic           core_busy, core_prog_susp, core_erase_susp, core_any_prot, core_all_prot,
   input fsr_pkg::fsr_cmd_type cmd_kind,
   input wire logic           cmd_valid, cmd_end, hold_abort, soft_reset_req, op_done, op_fail, op_aborted,
   // block outputs
   input wire logic           cmd_grant, cmd_refuse, soft_reset_go, global_protect_go, global_unprotect_go,
   input wire logic           protection_lock_bit, soft_reset_permit, lockdown_permit
);
   logic freeze_ask_q;
   logic frozen_q;

   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);

   // -----------------------------------------------------------------
   // freeze tracker
   // -----------------------------------------------------------------
   // remembers a granted freeze, so the permit must stay low for good
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         freeze_ask_q <= 1'b0;
         frozen_q     <= 1'b0;
      end else begin
         freeze_ask_q <= cmd_valid && (cmd_kind == FSR_CMD_FREEZE);
         frozen_q     <= frozen_q || (freeze_ask_q && cmd_grant);
      end
   end

   // -----------------------------------------------------------------
   // assertions
   // -----------------------------------------------------------------
   a_one_answer: assert property (cmd_valid |=> (cmd_grant ^ cmd_refuse))
      else $error("request without exactly one answer");
   a_answer_cause: assert property ((cmd_grant || cmd_refuse) |-> $past(cmd_valid))
      else $error("answer without request");
   a_lock_refuses: assert property (cmd_valid && protection_lock_bit && (cmd_kind == FSR_CMD_PROTECT ||
      cmd_kind == FSR_CMD_UNPROTECT) |=> cmd_refuse)
      else $error("sector change taken while locked");
   a_permit_refuses: assert property (cmd_valid && !lockdown_permit && (cmd_kind == FSR_CMD_LOCKDOWN ||
      cmd_kind == FSR_CMD_FREEZE) |=> cmd_refuse)
      else $error("lockdown taken without permit");
   a_reset_go_cause: assert property (soft_reset_go |-> $past(soft_reset_req) && $past(soft_reset_permit))
      else $error("soft reset without permit");
   a_reset_ignored: assert property (soft_reset_req && !soft_reset_permit |=> !soft_reset_go)
      else $error("soft reset not ignored");
   a_reset_keeps_bits: assert property (soft_reset_go |=> $stable(soft_reset_permit)
      && $stable(lockdown_permit) && $stable(protection_lock_bit))
      else $error("soft reset changed a kept bit");
   a_global_prior: assert property (global_protect_go || global_unprotect_go |-> !$past(protection_lock_bit))
      else $error("global operation while locked");
   a_global_single: assert property (!(global_protect_go && global_unprotect_go))
      else $error("both global operations at once");
   a_lock_clear_wp: assert property ($fell(protection_lock_bit) |-> wp_pin_n)
      else $error("lock cleared while pin asserted");
   a_permit_frame: assert property ($changed(soft_reset_permit) |-> spi_cs_n)
      else $error("reset permit changed inside a frame");
   a_freeze_holds: assert property (frozen_q |=> !lockdown_permit)
      else $error("lockdown permit up after freeze");
endmodule

bind fsr_status_ctrl fsr_status_ctrl_checker u_checker (.*);

// ### test/fsr_spi_host.sv
// serial host model that drives frames and samples status
`timescale 1ns/100ps

module fsr_spi_host (
   // link pins
   output logic      spi_sclk, spi_cs_n, spi_mosi,
   input wire logic  spi_miso
);
   // clock parked low outside frames, data line starts high
   initial begin
      spi_sclk = 1'b0;
      spi_cs_n = 1'b1;
      spi_mosi = 1'b1;
   end

   // frame of n bits, msb first; keeps last 16 read bits
   task automatic xfer(input logic [23:0] d, input int n, output logic [15:0] rd);
      rd = 16'h0000;
      spi_cs_n = 1'b0;
      for (int i = 0; i < n; i++) begin
         spi_mosi = d[23 - i];
         #3 spi_sclk = 1'b1;
         rd = {rd[14:0], spi_miso};
         #3 spi_sclk = 1'b0;
      end
      #3 spi_cs_n = 1'b1;
      // released line must not keep looking valid
      spi_mosi = ~spi_mosi;
   endtask
endmodule

// ### test/fsr_status_ctrl_tb.sv
// self-checking bench of the flash status register block
`timescale 1ns/100ps

module fsr_status_ctrl_tb;
   import fsr_pkg::*;
   logic        clk_sys, reset, wp_pin_n, busy, psus, esus, anyp, allp;
   logic        cmd_valid, cmd_end, hold_abort, rst_req, op_done, op_fail, op_aborted;
   fsr_cmd_type cmd_kind;
   logic        sclk, cs_n, mosi, miso, grant, refuse, rst_go, gp_go, gu_go, lock, rperm, lperm;
   logic [15:0] st;
   int          fail_count, compares, cycles, gp_n, gu_n, rs_n;

   fsr_status_ctrl dut (.clk_sys(clk_sys), .reset(reset), .spi_sclk(sclk), .spi_cs_n(cs_n),
      .spi_mosi(mosi), .spi_miso(miso), .wp_pin_n(wp_pin_n), .core_busy(busy), .core_prog_susp(psus),
      .core_erase_susp(esus), .core_any_prot(anyp), .core_all_prot(allp), .cmd_valid(cmd_valid),
      .cmd_kind(cmd_kind), .cmd_end(cmd_end), .hold_abort(hold_abort), .soft_reset_req(rst_req),
      .op_done(op_done), .op_fail(op_fail), .op_aborted(op_aborted), .cmd_grant(grant),
      .cmd_refuse(refuse), .soft_reset_go(rst_go), .global_protect_go(gp_go), .global_unprotect_go(gu_go),
      .protection_lock_bit(lock), .soft_reset_permit(rperm), .lockdown_permit(lperm));
   fsr_spi_host host (.spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi), .spi_miso(miso));

   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   // pulse counters and hang guard
   always @(posedge clk_sys) begin
      cycles++;
      gp_n += (gp_go === 1'b1);
      gu_n += (gu_go === 1'b1);
      rs_n += (rst_go === 1'b1);
      if (cycles == 6000) begin
         fail_count++;
         finish_test();
      end
   end

   // -----------------------------------------------------------------
   // access tasks
   // -----------------------------------------------------------------
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      compares++;
      if (g !== e) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   // frame then a gap long enough for the effects to land
   task automatic fr(input logic [23:0] d, input int n);
      host.xfer(d, n, st);
      repeat (10) @(negedge clk_sys);
   endtask
   task automatic rd(input logic [15:0] e);
      fr({OP_READ_STATUS, 16'h0000}, 24);
      chk("status", e, st);
   endtask
   task automatic wen();
      fr({OP_WRITE_ENABLE, 16'h0000}, 8);
   endtask
   task automatic eng(input fsr_cmd_type k, input logic [1:0] e);
      @(negedge clk_sys);
      cmd_kind = k;
      cmd_valid = 1'b1;
      @(negedge clk_sys);
      cmd_valid = 1'b0;
      chk("grant refuse", 16'(e), 16'({grant, refuse}));
   endtask
   // e picks end, hold abort or soft reset; zero means an operation result
   task automatic evt(input logic [2:0] e, input logic f, input logic a);
      @(negedge clk_sys);
      {cmd_end, hold_abort, rst_req} = e;
      {op_fail, op_aborted} = {f, a};
      op_done = (e == 3'h0);
      @(negedge clk_sys);
      {cmd_end, hold_abort, rst_req, op_done, op_fail, op_aborted} = '0;
      repeat (6) @(negedge clk_sys);
   endtask
   task automatic finish_test();
      $display("comparisons %0d, mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // -----------------------------------------------------------------
   // test sequence
   // -----------------------------------------------------------------
   initial begin
      reset = 1'b1;
      wp_pin_n = 1'b1;
      cmd_kind = FSR_CMD_PROG_ERASE;
      {busy, psus, esus, anyp, allp, cmd_valid, cmd_end, hold_abort, rst_req, op_done, op_fail, op_aborted} = '0;
      repeat (12) @(negedge clk_sys);
      reset = 1'b0;
      repeat (4) @(negedge clk_sys);
      rd(16'h1000);
      chk("kept bits", 16'h0000, 16'({lock, rperm, lperm}));
      evt(3'h1, 1'b0, 1'b0);
      chk("reset go count", 16'h0000, 16'(rs_n));
      $display("test power-up done");
      wen();
      rd(16'h1200);
      fr({OP_WRITE_DISABLE, 16'h0000}, 4);
      rd(16'h1200);
      eng(FSR_CMD_PROG_ERASE, 2'b10);
      evt(3'h4, 1'b0, 1'b0);
      rd(16'h1000);
      wen();
      evt(3'h2, 1'b0, 1'b0);
      rd(16'h1000);
      wen();
      fr({OP_WRITE_DISABLE, 16'h0000}, 8);
      rd(16'h1000);
      eng(FSR_CMD_PROG_ERASE, 2'b01);
      $display("test latch done");
      fr({OP_WRITE_STATUS_ONE, 8'h80, 8'h00}, 16);
      rd(16'h1000);
      wen();
      fr({OP_WRITE_STATUS_ONE, 8'hBC, 8'h00}, 16);
      rd(16'h9000);
      chk("protect go count", 16'h0001, 16'(gp_n));
      wen();
      eng(FSR_CMD_PROTECT, 2'b01);
      eng(FSR_CMD_UNPROTECT, 2'b01);
      fr({OP_WRITE_DISABLE, 16'h0000}, 8);
      wp_pin_n = 1'b0;
      wen();
      fr({OP_WRITE_STATUS_ONE, 8'h3C, 8'h00}, 16);
      rd(16'h8000);
      chk("protect go count", 16'h0001, 16'(gp_n));
      wp_pin_n = 1'b1;
      wen();
      fr({OP_WRITE_STATUS_ONE, 8'h00, 8'h00}, 16);
      rd(16'h1000);
      chk("unprotect go count", 16'h0000, 16'(gu_n));
      wen();
      fr({OP_WRITE_STATUS_ONE, 8'h80, 8'h00}, 12);
      rd(16'h1000);
      wen();
      fr({OP_WRITE_STATUS_ONE, 8'h00, 8'h00}, 16);
      chk("unprotect go count", 16'h0001, 16'(gu_n));
      $display("test byte one done");
      wen();
      fr({OP_WRITE_STATUS_TWO, 8'h18, 8'hFF}, 24);
      rd(16'h1018);
      evt(3'h1, 1'b0, 1'b0);
      chk("reset go count", 16'h0001, 16'(rs_n));
      chk("kept bits", 16'h0003, 16'({lock, rperm, lperm}));
      wen();
      eng(FSR_CMD_LOCKDOWN, 2'b10);
      evt(3'h4, 1'b0, 1'b0);
      wen();
      eng(FSR_CMD_FREEZE, 2'b10);
      evt(3'h4, 1'b0, 1'b0);
      wen();
      fr({OP_WRITE_STATUS_TWO, 8'h08, 8'h00}, 16);
      rd(16'h1000);
      $display("test byte two done");
      {busy, psus, esus, anyp, allp} = 5'h1F;
      rd(16'h1D07);
      {busy, psus, esus, anyp, allp} = 5'h02;
      rd(16'h1400);
      anyp = 1'b0;
      evt(3'h0, 1'b1, 1'b0);
      rd(16'h3000);
      evt(3'h0, 1'b0, 1'b0);
      rd(16'h1000);
      evt(3'h0, 1'b1, 1'b1);
      rd(16'h1000);
      $display("test engine done");
      finish_test();
   end
endmodule
